/* File: hdl/msp_pkg.sv */
// Constants and types shared by the multi-mode serial port
package msp_pkg;

  // Register addresses
  localparam logic [15:0] ADDR_CTRL = 16'hFE34;
  localparam logic [15:0] ADDR_BUF  = 16'hFE35;
  localparam logic [15:0] ADDR_BAUD = 16'hFE36;

  // Values after reset
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [8:0]  BUF_RST        = 9'h000;
  localparam logic [7:0]  BAUD_RST       = 8'h00;
  localparam logic        PIN_IDLE_LEVEL = 1'b1;

  // Cycle time and baud multipliers
  localparam int          CLK_NS       = 10;
  localparam int          TCYC_NS      = 10;
  localparam int          TCYC_CLKS    = (TCYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SYNC_MULT_SH = 1;
  localparam int          UART_MULT_SH = 3;

  // Bit counter milestones
  localparam logic [3:0]  CNT_LAST_DATA = 4'h7;
  localparam logic [3:0]  CNT_STOP      = 4'h8;

  typedef enum logic [1:0] {
    MODE_SYNC8,
    MODE_UART,
    MODE_MASTER,
    MODE_SLAVE
  } msp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BITS,
    ST_NINTH,
    ST_HOLD,
    ST_RELEASE
  } msp_state_t;

  typedef struct packed {
    msp_mode_t modeSelect;
    logic      runningFlag;
    logic      receiveSelect;
    logic      bitOrderSelect;
    logic      overrunFlag;
    logic      transferEndFlag;
    logic      endInterruptEnable;
  } msp_ctrl_t;

  typedef struct packed {
    logic clkOut;
    logic clkOe;
    logic datOut;
    logic datOe;
  } msp_pin_t;

  // Both lines released
  localparam msp_pin_t PINS_IDLE = 4'hA;

endpackage : msp_pkg

/* File: hdl/msp_edge_detect.sv */
`timescale 1ns/10ps
// Edge detector for one serial pin
module msp_edge_detect #(
  parameter logic RST_LEVEL = msp_pkg::PIN_IDLE_LEVEL
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Pin
  input  wire logic sigIn,
  // Level of the previous cycle and edges
  output      logic level,
  output      logic rise,
  output      logic fall
);

  assign rise = sigIn & ~level;
  assign fall = ~sigIn & level;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= RST_LEVEL;
    end else begin
      level <= sigIn;
    end
  end

endmodule : msp_edge_detect

/* File: hdl/msp_baud_gen.sv */
`timescale 1ns/10ps
// Baud-rate tick generator for the serial port
module msp_baud_gen #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic [7:0] reload,
  input  wire logic       uartMode,
  input  wire logic       enable,
  input  wire logic       restart,
  input  wire logic       restartHalf,
  // One-cycle tick per baud period
  output      logic       tick
);

  logic [CNT_W-1:0] unitCnt;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] cnt;
  logic             reloadNow;

  assign unitCnt   = CNT_W'((int'(reload) + 1) * msp_pkg::TCYC_CLKS);
  assign period    = uartMode ? (unitCnt << msp_pkg::UART_MULT_SH)
                              : (unitCnt << msp_pkg::SYNC_MULT_SH);
  assign reloadNow = restart | restartHalf | ~enable;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (reloadNow) begin
      // One less, so the first period after a restart is as long as the rest
      cnt  <= (restartHalf ? (period >> 1) : period) - CNT_W'(1);
      tick <= 1'b0;
    end else if (cnt <= CNT_W'(1)) begin
      cnt  <= period;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt - CNT_W'(1);
      tick <= 1'b0;
    end
  end

endmodule : msp_baud_gen

/* File: hdl/msp_serial_port.sv */
`timescale 1ns/10ps
// Multi-mode serial port: registers, transfer engine and pin drivers
module msp_serial_port (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [15:0]       regAddr,
  input  wire logic [8:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output      logic [8:0]        regRdata,
  // Serial pins
  input  wire logic              clkIn,
  input  wire logic              datIn,
  output      msp_pkg::msp_pin_t pinOut,
  // Interrupt request
  output      logic              irqReq
);

  msp_pkg::msp_ctrl_t  ctrl;
  msp_pkg::msp_ctrl_t  next_ctrl;
  msp_pkg::msp_ctrl_t  wrVal;
  msp_pkg::msp_ctrl_t  baseCtrl;
  msp_pkg::msp_state_t state;
  msp_pkg::msp_state_t next_state;
  msp_pkg::msp_pin_t   next_pins;
  msp_pkg::msp_mode_t  modeNow;
  logic [8:0]          sbuf;
  logic [8:0]          next_sbuf;
  logic [7:0]          baud;
  logic [7:0]          shiftReg;
  logic [7:0]          next_shift;
  logic [7:0]          shiftIn;
  logic [7:0]          byteVal;
  logic [3:0]          bitCnt;
  logic [3:0]          next_bitCnt;
  logic [8:0]          relCnt;
  logic [8:0]          next_relCnt;
  logic [8:0]          relLoad;
  logic [8:0]          rdMux;
  logic                selCtrl;
  logic                selBuf;
  logic                selBaud;
  logic                wrCtrl;
  logic                wrBuf;
  logic                wrBaud;
  logic                isSync;
  logic                isUart;
  logic                isMaster;
  logic                isSlave;
  logic                isBus;
  logic                outBit;
  logic                nxtOut;
  logic                bufOut;
  logic                txDrive;
  logic                clkLvl;
  logic                clkRise;
  logic                clkFall;
  logic                datLvl;
  logic                datRise;
  logic                datFall;
  logic                busHigh;
  logic                startCond;
  logic                stopCond;
  logic                swStart;
  logic                uartRxStart;
  logic                bgEnable;
  logic                bgRestart;
  logic                tick;
  logic                hwSetRun;
  logic                hwClrRun;
  logic                hwEnd;
  logic                hwOvr;
  logic                loadByte;
  logic                loadNinth;

  // Address decode and read selection
  assign selCtrl = (regAddr == msp_pkg::ADDR_CTRL);
  assign selBuf  = (regAddr == msp_pkg::ADDR_BUF);
  assign selBaud = (regAddr == msp_pkg::ADDR_BAUD);
  assign wrCtrl  = regWr & selCtrl;
  assign wrBuf   = regWr & selBuf;
  assign wrBaud  = regWr & selBaud;
  assign wrVal   = msp_pkg::msp_ctrl_t'(regWdata[7:0]);
  assign rdMux   = selCtrl ? {1'b0, ctrl} :
                   selBuf  ? sbuf :
                   selBaud ? {1'b0, baud} : 9'h000;

  // Mode decode
  assign isSync   = (ctrl.modeSelect == msp_pkg::MODE_SYNC8);
  assign isUart   = (ctrl.modeSelect == msp_pkg::MODE_UART);
  assign isMaster = (ctrl.modeSelect == msp_pkg::MODE_MASTER);
  assign isSlave  = (ctrl.modeSelect == msp_pkg::MODE_SLAVE);
  // A control write that starts a transfer also picks its mode
  assign modeNow  = wrCtrl ? wrVal.modeSelect : ctrl.modeSelect;
  assign isBus    = (modeNow == msp_pkg::MODE_MASTER) | (modeNow == msp_pkg::MODE_SLAVE);

  // Shift path in the selected bit order
  assign outBit  = ctrl.bitOrderSelect ? shiftReg[7] : shiftReg[0];
  assign shiftIn = ctrl.bitOrderSelect ? {shiftReg[6:0], datIn}
                                       : {datIn, shiftReg[7:1]};
  assign nxtOut  = ctrl.bitOrderSelect ? shiftIn[7] : shiftIn[0];
  assign bufOut  = ctrl.bitOrderSelect ? sbuf[7] : sbuf[0];
  assign txDrive = ~ctrl.receiveSelect & ctrl.runningFlag;

  // Bus conditions: data edge while the clock stays high
  assign busHigh   = clkIn & clkLvl;
  assign startCond = datFall & busHigh;
  assign stopCond  = datRise & busHigh;

  // Transfer starts
  assign swStart     = wrCtrl & wrVal.runningFlag & ~ctrl.runningFlag;
  assign uartRxStart = isUart & ctrl.receiveSelect & datFall
                     & (state == msp_pkg::ST_IDLE);

  // Baud generator control
  assign bgEnable  = (state != msp_pkg::ST_IDLE) & ~isSlave;
  assign bgRestart = wrBaud | swStart;
  assign relLoad   = 9'((int'(baud) + 1) * msp_pkg::TCYC_CLKS);

  // Overrun sources
  assign hwOvr = (clkFall & ~ctrl.runningFlag & ~isUart)
               | (hwEnd & ctrl.transferEndFlag & ~isSync)
               | (isSlave & startCond);

  msp_edge_detect u_clkEdge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sigIn   (clkIn),
    .level   (clkLvl),
    .rise    (clkRise),
    .fall    (clkFall)
  );

  msp_edge_detect u_datEdge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sigIn   (datIn),
    .level   (datLvl),
    .rise    (datRise),
    .fall    (datFall)
  );

  msp_baud_gen u_baud (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .reload      (baud),
    .uartMode    (modeNow == msp_pkg::MODE_UART),
    .enable      (bgEnable),
    .restart     (bgRestart),
    .restartHalf (uartRxStart),
    .tick        (tick)
  );

  // Transfer engine
  always_comb begin
    next_state  = state;
    next_shift  = shiftReg;
    next_bitCnt = bitCnt;
    next_pins   = pinOut;
    next_relCnt = relCnt;
    hwSetRun    = 1'b0;
    hwClrRun    = 1'b0;
    hwEnd       = 1'b0;
    loadByte    = 1'b0;
    loadNinth   = 1'b0;
    byteVal     = shiftIn;
    case (state)
      msp_pkg::ST_IDLE: begin
        next_pins   = msp_pkg::PINS_IDLE;
        next_bitCnt = 4'h0;
        next_shift  = sbuf[7:0];
        if (uartRxStart) begin
          hwSetRun   = 1'b1;
          next_state = msp_pkg::ST_BITS;
        end else if (swStart && modeNow == msp_pkg::MODE_MASTER) begin
          next_pins.datOe = 1'b1;
          next_state      = msp_pkg::ST_START;
        end else if (swStart && modeNow == msp_pkg::MODE_UART) begin
          next_pins.datOut = 1'b0;
          next_pins.datOe  = ~wrVal.receiveSelect;
          next_state       = msp_pkg::ST_BITS;
        end else if (swStart && modeNow == msp_pkg::MODE_SYNC8) begin
          next_pins.clkOe = 1'b1;
          next_pins.datOe = ~wrVal.receiveSelect;
          next_state      = msp_pkg::ST_BITS;
        end
      end
      msp_pkg::ST_START: begin
        if ((isMaster && tick) || (isSlave && clkFall)) begin
          next_pins.clkOe = isMaster;
          next_pins.datOe = txDrive & ~outBit;
          next_state      = msp_pkg::ST_BITS;
        end
      end
      msp_pkg::ST_BITS: begin
        if (isSync) begin
          if (tick && pinOut.clkOut) begin
            next_pins.clkOut = 1'b0;
            next_pins.datOut = outBit;
          end else if (tick) begin
            next_pins.clkOut = 1'b1;
            next_shift       = shiftIn;
            next_bitCnt      = bitCnt + 4'h1;
            if (bitCnt == msp_pkg::CNT_LAST_DATA) begin
              loadByte   = 1'b1;
              hwEnd      = 1'b1;
              hwClrRun   = 1'b1;
              next_state = msp_pkg::ST_IDLE;
            end
          end
        end else if (isUart) begin
          if (tick) begin
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == 4'h0) begin
              next_pins.datOut = outBit;
            end else if (bitCnt < msp_pkg::CNT_STOP) begin
              next_shift       = shiftIn;
              next_pins.datOut = nxtOut;
            end else if (bitCnt == msp_pkg::CNT_STOP) begin
              next_shift       = shiftIn;
              next_pins.datOut = 1'b1;
              loadByte         = 1'b1;
            end else begin
              loadNinth  = 1'b1;
              hwEnd      = 1'b1;
              hwClrRun   = 1'b1;
              next_state = msp_pkg::ST_IDLE;
            end
          end
        end else if (isMaster) begin
          if (tick && pinOut.clkOe) begin
            next_pins.clkOe = 1'b0;
          end else if (tick && clkIn) begin
            next_pins.clkOe = 1'b1;
            next_bitCnt     = bitCnt + 4'h1;
            if (bitCnt < msp_pkg::CNT_LAST_DATA) begin
              next_shift      = shiftIn;
              next_pins.datOe = txDrive & ~nxtOut;
            end else if (bitCnt == msp_pkg::CNT_LAST_DATA) begin
              next_shift      = shiftIn;
              loadByte        = 1'b1;
              next_pins.datOe = ctrl.receiveSelect & ~sbuf[8];
            end else begin
              loadNinth       = 1'b1;
              hwEnd           = 1'b1;
              next_pins.datOe = 1'b0;
              next_state      = msp_pkg::ST_HOLD;
            end
          end
        end else begin
          if (clkRise) begin
            next_shift = shiftIn;
          end else if (clkFall) begin
            next_bitCnt     = bitCnt + 4'h1;
            next_pins.datOe = txDrive & ~outBit;
            if (bitCnt == msp_pkg::CNT_LAST_DATA) begin
              next_pins.clkOe = 1'b1;
              next_pins.datOe = 1'b0;
              byteVal         = shiftReg;
              loadByte        = 1'b1;
              hwEnd           = 1'b1;
              next_state      = msp_pkg::ST_HOLD;
            end
          end
        end
      end
      msp_pkg::ST_HOLD: begin
        if (!ctrl.runningFlag) begin
          next_pins  = msp_pkg::PINS_IDLE;
          next_state = msp_pkg::ST_IDLE;
        end else if (!ctrl.transferEndFlag) begin
          next_shift  = sbuf[7:0];
          next_bitCnt = 4'h0;
          if (isMaster) begin
            next_pins.datOe = txDrive & ~bufOut;
            next_state      = msp_pkg::ST_BITS;
          end else begin
            next_pins.datOe = ctrl.receiveSelect & ~sbuf[8];
            next_relCnt     = relLoad;
            next_state      = msp_pkg::ST_RELEASE;
          end
        end
      end
      msp_pkg::ST_RELEASE: begin
        if (relCnt <= 9'h001) begin
          next_pins.clkOe = 1'b0;
          next_state      = msp_pkg::ST_NINTH;
        end else begin
          next_relCnt = relCnt - 9'h001;
        end
      end
      msp_pkg::ST_NINTH: begin
        if (clkRise) begin
          loadNinth = 1'b1;
          if (!ctrl.receiveSelect && datIn) begin
            // No acknowledge from the master ends slave transmission
            hwClrRun   = 1'b1;
            next_pins  = msp_pkg::PINS_IDLE;
            next_state = msp_pkg::ST_IDLE;
          end
        end else if (clkFall) begin
          next_bitCnt     = 4'h0;
          next_pins.datOe = txDrive & ~outBit;
          next_state      = msp_pkg::ST_BITS;
        end
      end
      default: begin
        next_state = msp_pkg::ST_IDLE;
      end
    endcase
    // Bus conditions override any slave phase
    if (isSlave && startCond) begin
      hwSetRun    = ctrl.receiveSelect;
      next_bitCnt = 4'h0;
      next_shift  = sbuf[7:0];
      next_pins   = msp_pkg::PINS_IDLE;
      next_state  = msp_pkg::ST_START;
    end else if (isSlave && stopCond) begin
      hwClrRun   = 1'b1;
      hwEnd      = 1'b1;
      next_pins  = msp_pkg::PINS_IDLE;
      next_state = msp_pkg::ST_IDLE;
    end
    // Open-drain lines only ever pull low
    if (isBus) begin
      next_pins.clkOut = 1'b0;
      next_pins.datOut = 1'b0;
    end
  end

  // Control register: hardware sets win over software clears
  assign baseCtrl = wrCtrl ? wrVal : ctrl;

  always_comb begin
    next_ctrl                 = baseCtrl;
    next_ctrl.runningFlag     = hwSetRun | (baseCtrl.runningFlag & ~hwClrRun);
    next_ctrl.overrunFlag     = baseCtrl.overrunFlag | hwOvr;
    next_ctrl.transferEndFlag = baseCtrl.transferEndFlag | hwEnd;
  end

  // Buffer: hardware loads win over a software write
  always_comb begin
    next_sbuf = wrBuf ? regWdata : sbuf;
    if (loadByte) begin
      next_sbuf[7:0] = byteVal;
    end
    if (loadNinth && !isSync) begin
      next_sbuf[8] = datIn;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= msp_pkg::msp_ctrl_t'(msp_pkg::CTRL_RST);
      sbuf     <= msp_pkg::BUF_RST;
      baud     <= msp_pkg::BAUD_RST;
      state    <= msp_pkg::ST_IDLE;
      shiftReg <= 8'h00;
      bitCnt   <= 4'h0;
      relCnt   <= 9'h000;
      pinOut   <= msp_pkg::PINS_IDLE;
      regRdata <= 9'h000;
      irqReq   <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      sbuf     <= next_sbuf;
      baud     <= wrBaud ? regWdata[7:0] : baud;
      state    <= next_state;
      shiftReg <= next_shift;
      bitCnt   <= next_bitCnt;
      relCnt   <= next_relCnt;
      pinOut   <= next_pins;
      regRdata <= regRd ? rdMux : 9'h000;
      irqReq   <= next_ctrl.endInterruptEnable & next_ctrl.transferEndFlag;
    end
  end

endmodule : msp_serial_port

/* File: tb/msp_serial_port_properties.sv */
`timescale 1ns/10ps
// Port-level checker for the multi-mode serial port
module msp_serial_port_properties (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [15:0]       regAddr,
  input wire logic [8:0]        regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [8:0]        regRdata,
  // Serial pins and interrupt request
  input wire logic              clkIn,
  input wire logic              datIn,
  input wire msp_pkg::msp_pin_t pinOut,
  input wire logic              irqReq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire        ctrlHit = regAddr == msp_pkg::ADDR_CTRL;
  wire        bufHit  = regAddr == msp_pkg::ADDR_BUF;
  wire        mapped  = ctrlHit || bufHit || regAddr == msp_pkg::ADDR_BAUD;
  logic [1:0] modeSh;
  logic [7:0] baudSh;
  logic       lastClk;
  logic       seenEdge;
  logic [9:0] phaseCnt;
  wire        clkEdge = pinOut.clkOut != lastClk;
  // Shadows of software settings and the spacing of clock pin changes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeSh   <= 2'h0;
      baudSh   <= 8'h00;
      lastClk  <= 1'b1;
      seenEdge <= 1'b0;
      phaseCnt <= 10'h000;
    end else begin
      if (regWr && ctrlHit) modeSh <= regWdata[7:6];
      if (regWr && regAddr == msp_pkg::ADDR_BAUD) baudSh <= regWdata[7:0];
      lastClk  <= pinOut.clkOut;
      seenEdge <= regWr ? 1'b0 : (seenEdge || clkEdge);
      phaseCnt <= clkEdge ? 10'h001 : phaseCnt + 10'h001;
    end
  end
  sequence s_ctrlRd;
    regRd && ctrlHit;
  endsequence
  property p_rdIdle;
    !regRd |=> regRdata == 9'h000;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data not zero outside its slot");
  property p_unmapped;
    regRd && !mapped |=> regRdata == 9'h000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  property p_narrow;
    regRd && !bufHit |=> !regRdata[8];
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("bit 8 set on an eight-bit register");
  property p_irqLevel;
    s_ctrlRd |=> (regRdata[0] && regRdata[1]) == $past(irqReq);
  endproperty
  a_irqLevel: assert property (p_irqLevel)
    else $error("interrupt request disagrees with enable and end flag");
  property p_irqSticky;
    $fell(irqReq) |-> $past(regWr && ctrlHit);
  endproperty
  a_irqSticky: assert property (p_irqSticky)
    else $error("interrupt request dropped without a control write");
  property p_endSticky;
    s_ctrlRd ##1 (regRdata[1] && regRd && ctrlHit) |=> regRdata[1];
  endproperty
  a_endSticky: assert property (p_endSticky)
    else $error("end flag cleared by itself");
  property p_ovrSticky;
    s_ctrlRd ##1 (regRdata[2] && regRd && ctrlHit) |=> regRdata[2];
  endproperty
  a_ovrSticky: assert property (p_ovrSticky)
    else $error("overrun flag cleared by itself");
  property p_busOpenDrain;
    modeSh[1] && $past(modeSh[1]) && $past(modeSh[1], 2)
      |-> !(pinOut.clkOe && pinOut.clkOut) && !(pinOut.datOe && pinOut.datOut);
  endproperty
  a_busOpenDrain: assert property (p_busOpenDrain)
    else $error("bus mode drives a line high");
  property p_syncPhase;
    clkEdge && seenEdge && modeSh == 2'h0 && pinOut.clkOe
      |-> phaseCnt == ({2'h0, baudSh} + 10'h001) * 10'h002;
  endproperty
  a_syncPhase: assert property (p_syncPhase)
    else $error("sync clock phase length wrong");
endmodule : msp_serial_port_properties

bind msp_serial_port msp_serial_port_properties chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .clkIn(clkIn),
  .datIn(datIn), .pinOut(pinOut), .irqReq(irqReq));

/* File: tb/msp_peer_model.sv */
`timescale 1ns/10ps
// Serial peer on the clock and data lines, with pull-ups on both
module msp_peer_model (
  // Device pins
  input  wire msp_pkg::msp_pin_t pinOut,
  // Bench controls
  input  wire logic              peerClk,
  input  wire logic              peerDat,
  input  wire logic              msbFirst,
  input  wire logic [7:0]        respByte,
  input  wire logic              arm,
  // Resolved lines and captured byte
  output      logic              clkIn,
  output      logic              datIn,
  output      logic [7:0]        capByte
);
  logic       respBit = 1'b1;
  logic [2:0] idx = 3'h0;
  // Wired-AND: a released line floats high unless a party pulls it low
  assign clkIn = (pinOut.clkOe ? pinOut.clkOut : 1'b1) & peerClk;
  assign datIn = (pinOut.datOe ? pinOut.datOut : 1'b1) & peerDat & respBit;
  // Next reply bit goes out on each falling clock
  always @(negedge clkIn or negedge arm) begin
    if (!arm) begin
      idx     <= 3'h0;
      respBit <= 1'b1;
    end else begin
      respBit <= msbFirst ? respByte[3'h7 - idx] : respByte[idx];
      idx     <= idx + 3'h1;
    end
  end
  always @(posedge clkIn) begin
    if (arm) capByte <= msbFirst ? {capByte[6:0], datIn} : {datIn, capByte[7:1]};
  end
endmodule : msp_peer_model

/* File: tb/msp_serial_port_tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench for the multi-mode serial port
module msp_serial_port_tb_top;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [15:0]       regAddr = 16'h0000;
  logic [8:0]        regWdata = 9'h000;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [8:0]        regRdata;
  logic              clkIn;
  logic              datIn;
  msp_pkg::msp_pin_t pinOut;
  logic              irqReq;
  logic              peerClk = 1'b1;
  logic              peerDat = 1'b1;
  logic              msbFirst = 1'b0;
  logic              arm = 1'b0;
  logic [7:0]        respByte = 8'hFF;
  logic [7:0]        capByte;
  logic [8:0]        rdVal;
  int                failures = 0;
  int                samplesChecked = 0;
  int                cycles = 0;

  always #5 sys_clk = ~sys_clk;

  msp_serial_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .clkIn(clkIn), .datIn(datIn), .pinOut(pinOut), .irqReq(irqReq));
  msp_peer_model peer_u (.pinOut(pinOut), .peerClk(peerClk), .peerDat(peerDat),
    .msbFirst(msbFirst), .respByte(respByte), .arm(arm), .clkIn(clkIn),
    .datIn(datIn), .capByte(capByte));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [8:0] d);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    rdVal = regRdata;
  endtask : rd

  // Poll the control register until one bit reaches a value
  task automatic waitBit(input int b, input logic v);
    int n;
    n = 0;
    rd(msp_pkg::ADDR_CTRL);
    while (rdVal[b] !== v && n < 400) begin
      rd(msp_pkg::ADDR_CTRL);
      n++;
    end
    chk(rdVal[b], v);
  endtask : waitBit

  // Length in cycles of the next low phase on the clock or data line
  task automatic lowLen(input logic useDat, input int exp);
    int n;
    n = 0;
    while ((useDat ? datIn : clkIn) !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    n = 0;
    while ((useDat ? datIn : clkIn) === 1'b0 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n[8:0], exp[8:0]);
  endtask : lowLen

  task automatic overrunIdle();
    wr(msp_pkg::ADDR_CTRL, 9'h000);
    peerClk <= 1'b0;
    repeat (3) @(posedge sys_clk);
    peerClk <= 1'b1;
    waitBit(2, 1'b1);
    repeat (20) @(posedge sys_clk);
    rd(msp_pkg::ADDR_CTRL);
    chk(rdVal[2], 1'b1);
    wr(msp_pkg::ADDR_CTRL, 9'h000);
    rd(msp_pkg::ADDR_CTRL);
    chk(rdVal[2], 1'b0);
  endtask : overrunIdle

  // Mode 0 exchange; the wire-AND makes the line carry tx & resp
  task automatic syncXfer(input logic rx, input logic msb, input logic [7:0] tx,
                          input logic [7:0] resp);
    msbFirst <= msb;
    respByte <= resp;
    arm      <= 1'b1;
    wr(msp_pkg::ADDR_BAUD, 9'h002);
    wr(msp_pkg::ADDR_BUF, {1'b1, tx});
    wr(msp_pkg::ADDR_CTRL, {4'h1, rx, msb, 3'h1});
    rd(msp_pkg::ADDR_CTRL);
    chk(rdVal[5], 1'b1);
    lowLen(1'b0, 6);
    waitBit(1, 1'b1);
    rd(msp_pkg::ADDR_CTRL);
    chk(rdVal[5:1], {1'b0, rx, msb, 2'h1});
    chk(irqReq, 1'b1);
    rd(msp_pkg::ADDR_BUF);
    chk(rdVal, {1'b1, tx & resp});
    chk(capByte, tx & resp);
    wr(msp_pkg::ADDR_CTRL, 9'h000);
    chk(irqReq, 1'b0);
    arm <= 1'b0;
    @(posedge sys_clk);
  endtask : syncXfer

  // Mode 2 byte: clock held low after the ninth bit until running is cleared
  task automatic masterXfer();
    wr(msp_pkg::ADDR_BAUD, 9'h000);
    wr(msp_pkg::ADDR_BUF, 9'h0A5);
    wr(msp_pkg::ADDR_CTRL, 9'h0A0);
    waitBit(1, 1'b1);
    chk(rdVal[5], 1'b1);
    chk(clkIn, 1'b0);
    rd(msp_pkg::ADDR_BUF);
    chk(rdVal, 9'h1A5);
    wr(msp_pkg::ADDR_CTRL, 9'h000);
    repeat (2) @(posedge sys_clk);
    chk(clkIn, 1'b1);
  endtask : masterXfer

  task automatic uartTx();
    wr(msp_pkg::ADDR_BAUD, 9'h001);
    wr(msp_pkg::ADDR_BUF, 9'h055);
    wr(msp_pkg::ADDR_CTRL, 9'h060);
    lowLen(1'b1, 16);
    waitBit(5, 1'b0);
    chk(rdVal[1], 1'b1);
    rd(msp_pkg::ADDR_BUF);
    chk(rdVal, 9'h155);
    wr(msp_pkg::ADDR_CTRL, 9'h062);
    waitBit(5, 1'b0);
    chk(rdVal[2], 1'b1);
    wr(msp_pkg::ADDR_CTRL, 9'h000);
  endtask : uartTx

  task automatic slaveStartStop();
    wr(msp_pkg::ADDR_CTRL, 9'h0D0);
    peerDat <= 1'b0;
    waitBit(5, 1'b1);
    chk(rdVal[2], 1'b1);
    peerDat <= 1'b1;
    waitBit(1, 1'b1);
    chk(rdVal[5], 1'b0);
    wr(msp_pkg::ADDR_CTRL, 9'h000);
  endtask : slaveStartStop

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    for (int a = 0; a < 4; a++) begin
      rd(16'hFE34 + a[15:0]);
      chk(rdVal, 9'h000);
    end
    for (int m = 0; m < 4; m++) begin
      wr(msp_pkg::ADDR_CTRL, {1'b0, m[1:0], 6'h00});
      rd(msp_pkg::ADDR_CTRL);
      chk(rdVal, {1'b0, m[1:0], 6'h00});
    end
    wr(msp_pkg::ADDR_BUF, 9'h1A5);
    wr(16'hFE37, 9'h0FF);
    rd(msp_pkg::ADDR_BUF);
    chk(rdVal, 9'h1A5);
    rd(16'hFE37);
    chk(rdVal, 9'h000);
    overrunIdle();
    syncXfer(1'b0, 1'b0, 8'hC3, 8'hFF);
    syncXfer(1'b0, 1'b1, 8'hC3, 8'hFF);
    syncXfer(1'b1, 1'b1, 8'hFF, 8'h4B);
    syncXfer(1'b1, 1'b0, 8'hFF, 8'h2D);
    uartTx();
    masterXfer();
    slaveStartStop();
    print_verdict();
  end
endmodule : msp_serial_port_tb_top
